// File: logic/crpm_top.sv
/*
  clock, reset and power-mode controller: derives the high-speed, usb,
  fixed-rate and slow clock enables and the divided auxiliary clock levels, combines reset sources and
  gates clocks per power mode. assumes reference, pll and low-frequency
  crystal edges arrive as one-cycle ticks synchronous to sys_clk.
*/
`timescale 1ns/1ps
module crpm_top
  import crpm_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic ref_tick,
  input wire logic pll_tick,
  input wire logic lf_tick,
  input wire logic lf_xtal_present,
  input wire logic hs_sel_pll,
  input wire logic [SEL_W-1:0] hs_presc_sel,
  input wire logic [DIV_W-1:0] fixed_div,
  input wire logic [DIV_W-1:0] aux1_div,
  input wire logic [DIV_W-1:0] aux2_div,
  input wire logic [SEL_W-1:0] mode_req,
  input wire logic por_req,
  input wire logic ext_rst_n,
  input wire logic [3:0] mod_rst_req,
  output logic core_clk_en,
  output logic periph_clk_en,
  output logic usb_clk_en,
  output logic fixed_clk_en,
  output logic slow_clk_en,
  output logic aux1_clk,
  output logic aux2_clk,
  output logic clk_src_slow,
  output logic dev_rst
);

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  function automatic logic [CNT_W-1:0] cnt_step(input logic [CNT_W-1:0] cnt,
                                                input logic [CNT_W-1:0] lim,
                                                input logic tick);
    if (!tick) begin
      return cnt;
    end
    return (cnt >= lim) ? CNT_ZERO : cnt + CNT_ONE;
  endfunction

  function automatic logic cnt_hit(input logic [CNT_W-1:0] cnt,
                                   input logic [CNT_W-1:0] lim,
                                   input logic tick);
    return tick && (cnt >= lim);
  endfunction

  crpm_mode_t mode_reg, mode_next;
  logic [CNT_W-1:0] pll_cnt_reg, pll_cnt_next;
  logic [CNT_W-1:0] slow_cnt_reg, slow_cnt_next;
  logic [CNT_W-1:0] fixed_cnt_reg, fixed_cnt_next;
  logic [CNT_W-1:0] aux1_cnt_reg, aux1_cnt_next;
  logic [CNT_W-1:0] aux2_cnt_reg, aux2_cnt_next;
  logic [CNT_W-1:0] pll_lim, slow_lim, fixed_lim, aux1_lim, aux2_lim;
  logic [2:0] presc_shift;
  logic run, pll_hit, slow_hit, fixed_hit, aux1_hit, aux2_hit;
  logic hs_tick, slow_tick, fixed_tick, sys_tick, target_slow;
  logic src_slow_reg, src_slow_next;
  logic core_en_reg, core_en_next;
  logic periph_en_reg, periph_en_next;
  logic usb_en_reg, usb_en_next;
  logic fixed_en_reg, fixed_en_next;
  logic slow_en_reg, slow_en_next;
  logic aux1_reg, aux1_next;
  logic aux2_reg, aux2_next;
  logic dev_rst_reg, dev_rst_next;

  // dividers and derived ticks; counters freeze in halt so phase is kept
  always_comb begin
    run = (mode_reg != PM_HALT);
    presc_shift = {1'b0, hs_presc_sel} + SHIFT_ONE;
    // smallest pll prescale is 2, so hs never exceeds twice the reference
    pll_lim = (PRESC_BASE << hs_presc_sel) - CNT_ONE;
    pll_hit = cnt_hit(pll_cnt_reg, pll_lim, pll_tick && run);
    pll_cnt_next = cnt_step(pll_cnt_reg, pll_lim, pll_tick && run);
    hs_tick = run && (hs_sel_pll ? pll_hit : ref_tick);
    // slow prescaler divides hs, scaled to the hs rate actually selected
    slow_lim = (hs_sel_pll ? (SLOW_DIV_PLL >> presc_shift) : SLOW_DIV_REF) - CNT_ONE;
    slow_hit = cnt_hit(slow_cnt_reg, slow_lim, hs_tick);
    slow_cnt_next = cnt_step(slow_cnt_reg, slow_lim, hs_tick);
    slow_tick = run && (lf_xtal_present ? lf_tick : slow_hit);
    // fixed-rate prescaler sees only the reference, never the hs selection
    fixed_lim = {3'h0, fixed_div};
    fixed_hit = cnt_hit(fixed_cnt_reg, fixed_lim, ref_tick && run);
    fixed_cnt_next = cnt_step(fixed_cnt_reg, fixed_lim, ref_tick && run);
    fixed_tick = fixed_hit;
    aux1_lim = {3'h0, aux1_div};
    aux2_lim = {3'h0, aux2_div};
    aux1_hit = cnt_hit(aux1_cnt_reg, aux1_lim, hs_tick);
    aux2_hit = cnt_hit(aux2_cnt_reg, aux2_lim, hs_tick);
    aux1_cnt_next = cnt_step(aux1_cnt_reg, aux1_lim, hs_tick);
    aux2_cnt_next = cnt_step(aux2_cnt_reg, aux2_lim, hs_tick);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pll_cnt_reg <= CNT_ZERO;
      slow_cnt_reg <= CNT_ZERO;
      fixed_cnt_reg <= CNT_ZERO;
      aux1_cnt_reg <= CNT_ZERO;
      aux2_cnt_reg <= CNT_ZERO;
    end else begin
      pll_cnt_reg <= pll_cnt_next;
      slow_cnt_reg <= slow_cnt_next;
      fixed_cnt_reg <= fixed_cnt_next;
      aux1_cnt_reg <= aux1_cnt_next;
      aux2_cnt_reg <= aux2_cnt_next;
    end
  end

  // mode, clock source and gated enables
  always_comb begin
    unique case (mode_req)
      MREQ_ACTIVE: mode_next = PM_ACTIVE;
      MREQ_PSAVE: mode_next = PM_PSAVE;
      MREQ_IDLE: mode_next = PM_IDLE;
      MREQ_HALT: mode_next = PM_HALT;
    endcase
    target_slow = (mode_reg != PM_ACTIVE);
    sys_tick = src_slow_reg ? slow_tick : hs_tick;
    // source flips only on a tick of the new source; in that cycle sys_tick still
    // follows the old source, so the new source's tick is not passed on
    src_slow_next = src_slow_reg;
    if ((target_slow != src_slow_reg) && (target_slow ? slow_tick : hs_tick)) begin
      src_slow_next = target_slow;
    end
    core_en_next = 1'b0;
    periph_en_next = 1'b0;
    usb_en_next = 1'b0;
    fixed_en_next = 1'b0;
    slow_en_next = 1'b0;
    aux1_next = aux1_reg;
    aux2_next = aux2_reg;
    unique case (mode_reg)
      PM_ACTIVE: begin
        core_en_next = sys_tick;
        periph_en_next = hs_tick && !src_slow_reg;
        usb_en_next = pll_tick;
        fixed_en_next = fixed_tick;
        slow_en_next = slow_tick;
        aux1_next = aux1_reg ^ aux1_hit;
        aux2_next = aux2_reg ^ aux2_hit;
      end
      PM_PSAVE: begin
        core_en_next = src_slow_reg && slow_tick;
        slow_en_next = slow_tick;
      end
      PM_IDLE: begin
        slow_en_next = slow_tick;
      end
      PM_HALT: begin
        slow_en_next = 1'b0;
      end
      default: begin
        slow_en_next = 1'b0;
      end
    endcase
    // reset sources merge here; the controller's own reset holds it too
    dev_rst_next = por_req || !ext_rst_n || (|mod_rst_req);
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_reg <= PM_ACTIVE;
      src_slow_reg <= 1'b0;
      core_en_reg <= 1'b0;
      periph_en_reg <= 1'b0;
      usb_en_reg <= 1'b0;
      fixed_en_reg <= 1'b0;
      slow_en_reg <= 1'b0;
      aux1_reg <= 1'b0;
      aux2_reg <= 1'b0;
      dev_rst_reg <= 1'b1;
    end else begin
      mode_reg <= mode_next;
      src_slow_reg <= src_slow_next;
      core_en_reg <= core_en_next;
      periph_en_reg <= periph_en_next;
      usb_en_reg <= usb_en_next;
      fixed_en_reg <= fixed_en_next;
      slow_en_reg <= slow_en_next;
      aux1_reg <= aux1_next;
      aux2_reg <= aux2_next;
      dev_rst_reg <= dev_rst_next;
    end
  end

  assign core_clk_en = core_en_reg;
  assign periph_clk_en = periph_en_reg;
  assign usb_clk_en = usb_en_reg;
  assign fixed_clk_en = fixed_en_reg;
  assign slow_clk_en = slow_en_reg;
  assign aux1_clk = aux1_reg;
  assign aux2_clk = aux2_reg;
  assign clk_src_slow = src_slow_reg;
  assign dev_rst = dev_rst_reg;

  property p_hs_rate;
    hs_tick && hs_sel_pll ##1 hs_sel_pll && $stable(hs_presc_sel) |-> !hs_tick;
  endproperty
  a_hs_rate: assert property (p_hs_rate) else $error("hs tick faster than limit");

  property p_slow_src;
    lf_xtal_present && (mode_reg != PM_HALT) |=> (slow_clk_en == $past(lf_tick));
  endproperty
  a_slow_src: assert property (p_slow_src) else $error("slow clock not from crystal");

  property p_hs_direct;
    mode_reg == PM_ACTIVE && !hs_sel_pll && !src_slow_reg |=> periph_clk_en == $past(ref_tick);
  endproperty
  a_hs_direct: assert property (p_hs_direct) else $error("direct hs not from reference");

  property p_usb;
    mode_reg == PM_ACTIVE && pll_tick |=> usb_clk_en;
  endproperty
  a_usb: assert property (p_usb) else $error("usb clock missed pll tick");

  property p_fixed;
    fixed_clk_en |-> $past(ref_tick) && $past(mode_reg == PM_ACTIVE);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed clock without reference tick");

  property p_aux;
    $changed(aux1_clk) |-> $past(aux1_hit) && $past(mode_reg == PM_ACTIVE);
  endproperty
  a_aux: assert property (p_aux) else $error("aux clock toggled without divider hit");

  property p_reset;
    !ext_rst_n || por_req |=> dev_rst;
  endproperty
  a_reset: assert property (p_reset) else $error("reset source not propagated");

  property p_active;
    mode_reg == PM_ACTIVE && !src_slow_reg && hs_tick |=> core_clk_en && periph_clk_en;
  endproperty
  a_active: assert property (p_active) else $error("active mode clock missing");

  property p_psave;
    mode_reg == PM_PSAVE |=> !periph_clk_en && (core_clk_en == $past(src_slow_reg && slow_tick));
  endproperty
  a_psave: assert property (p_psave) else $error("power save gating wrong");

  property p_idle;
    mode_reg == PM_IDLE |=> !core_clk_en && !periph_clk_en && !usb_clk_en && !fixed_clk_en
                           && (slow_clk_en == $past(slow_tick));
  endproperty
  a_idle: assert property (p_idle) else $error("idle mode gating wrong");

  sequence s_in_halt;
    (mode_reg == PM_HALT) [*2];
  endsequence

  property p_halt;
    s_in_halt |-> $stable(slow_cnt_reg) && $stable(aux1_cnt_reg) && $stable(pll_cnt_reg)
                 && !core_clk_en && !slow_clk_en && $stable(aux1_clk);
  endproperty
  a_halt: assert property (p_halt) else $error("activity during halt");

  sequence s_switch;
    ##1 $changed(src_slow_reg);
  endsequence

  property p_switch;
    (src_slow_reg ? hs_tick : slow_tick) == 1'b0 |-> not s_switch;
  endproperty
  a_switch: assert property (p_switch) else $error("source switched off a tick");

  property p_aux2;
    $changed(aux2_clk) |-> $past(aux2_hit) && $past(mode_reg == PM_ACTIVE);
  endproperty
  a_aux2: assert property (p_aux2) else $error("aux2 clock toggled without divider hit");

  property p_mod_reset;
    (|mod_rst_req) |=> dev_rst;
  endproperty
  a_mod_reset: assert property (p_mod_reset) else $error("module reset not propagated");

  property p_reset_clear;
    ext_rst_n && !por_req && !(|mod_rst_req) |=> !dev_rst;
  endproperty
  a_reset_clear: assert property (p_reset_clear) else $error("reset held with no source");

  property p_periph_off;
    mode_reg != PM_ACTIVE |=> !periph_clk_en && !usb_clk_en && !fixed_clk_en;
  endproperty
  a_periph_off: assert property (p_periph_off) else $error("peripheral clock outside active");

endmodule

// File: logic/crpm_pkg.sv
/*
  constants, mode encodings and divider limits for the clock, reset and
  power-mode controller. assumes one 20 MHz system clock; all derived clocks
  are carried as one-cycle enables or registered divided levels.
*/
package crpm_pkg;

  localparam int REF_HZ = 12000000;
  localparam int SLOW_HZ = 32768;
  localparam int HS_MAX_HZ = 24000000;
  localparam int PLL_MULT = 4;
  localparam int HS_PRESC_MIN = (PLL_MULT * REF_HZ) / HS_MAX_HZ;
  localparam int SLOW_DIV_REF_I = REF_HZ / SLOW_HZ;

  localparam int CNT_W = 11;
  localparam int DIV_W = 8;
  localparam int SEL_W = 2;

  localparam logic [CNT_W-1:0] CNT_ONE = 11'h001;
  localparam logic [CNT_W-1:0] CNT_ZERO = 11'h000;
  localparam logic [CNT_W-1:0] SLOW_DIV_REF = CNT_W'(SLOW_DIV_REF_I);
  localparam logic [CNT_W-1:0] SLOW_DIV_PLL = CNT_W'(SLOW_DIV_REF_I * PLL_MULT);
  localparam logic [CNT_W-1:0] PRESC_BASE = CNT_W'(HS_PRESC_MIN);
  localparam logic [2:0] SHIFT_ONE = 3'h1;

  localparam logic [SEL_W-1:0] MREQ_ACTIVE = 2'h0;
  localparam logic [SEL_W-1:0] MREQ_PSAVE = 2'h1;
  localparam logic [SEL_W-1:0] MREQ_IDLE = 2'h2;
  localparam logic [SEL_W-1:0] MREQ_HALT = 2'h3;

  typedef enum logic [3:0] {
    PM_ACTIVE = 4'h1,
    PM_PSAVE = 4'h2,
    PM_IDLE = 4'h4,
    PM_HALT = 4'h8
  } crpm_mode_t;

endpackage

// File: logic/crpm_end.sv
`timescale 1ns/1ps

// File: verif/crpm_xtal_model.sv
/*
  far side of the controller: 12 MHz reference, pll, optional 500 kHz crystal (one tick per LF_PERIOD = 40 cycles)
  and the reset push-button. assumes a 20 MHz sys_clk; every edge is a tick.
*/
`timescale 1ns/1ps
module crpm_xtal_model #(
  parameter int LF_PERIOD = 40
) (
  input wire logic sys_clk,
  input wire logic lf_fitted,
  input wire logic button,
  output logic ref_tick,
  output logic pll_tick,
  output logic lf_tick,
  output logic ext_rst_n
);
  int ref_acc = 0;
  int lf_cnt = 0;
  // pull-up keeps the reset pin high while the button is released
  assign ext_rst_n = !button;
  // one process owns every tick so each has a single driver
  initial begin
    ref_tick = 1'b0;
    pll_tick = 1'b0;
    lf_tick = 1'b0;
    forever begin
      @(posedge sys_clk);
      #2;
      ref_acc = (ref_acc + 12) % 20;
      ref_tick = (ref_acc < 12);
      // pll runs at 4x ref, faster than sys_clk, so it ticks every cycle
      pll_tick = 1'b1;
      lf_cnt = (lf_cnt + 1) % LF_PERIOD;
      // a missing crystal gives no edges at all
      lf_tick = lf_fitted && (lf_cnt == 0);
    end
  end
endmodule

// File: verif/clock_reset_power_modes_test.sv
/*
  self-checking bench for the clock, reset and power-mode controller.
  assumes crpm_top and the crystal model; counts enables against ticks.
*/
`timescale 1ns/1ps
module clock_reset_power_modes_test;
  import crpm_pkg::*;
  logic sys_clk, rst, lf_xtal_present, hs_sel_pll, por_req, button;
  logic [SEL_W-1:0] hs_presc_sel, mode_req;
  logic [DIV_W-1:0] fixed_div, aux1_div, aux2_div;
  logic [3:0] mod_rst_req;
  logic ref_tick, pll_tick, lf_tick, ext_rst_n;
  logic core_clk_en, periph_clk_en, usb_clk_en, fixed_clk_en, slow_clk_en;
  logic aux1_clk, aux2_clk, clk_src_slow, dev_rst, aux1_q, aux2_q;
  int n_mismatch = 0;
  int compares = 0;
  int c_ref, c_pll, c_lf, c_core, c_per, c_usb, c_fix, c_slow, c_a1, c_a2;

  crpm_top u_dut (.sys_clk, .rst, .ref_tick, .pll_tick, .lf_tick, .lf_xtal_present,
    .hs_sel_pll, .hs_presc_sel, .fixed_div, .aux1_div, .aux2_div, .mode_req, .por_req,
    .ext_rst_n, .mod_rst_req, .core_clk_en, .periph_clk_en, .usb_clk_en, .fixed_clk_en,
    .slow_clk_en, .aux1_clk, .aux2_clk, .clk_src_slow, .dev_rst);
  crpm_xtal_model u_xtal (.sys_clk, .lf_fitted(lf_xtal_present), .button, .ref_tick,
    .pll_tick, .lf_tick, .ext_rst_n);

  always @(posedge sys_clk) begin
    c_ref += int'(ref_tick);
    c_pll += int'(pll_tick);
    c_lf += int'(lf_tick);
    c_core += int'(core_clk_en === 1'b1);
    c_per += int'(periph_clk_en === 1'b1);
    c_usb += int'(usb_clk_en === 1'b1);
    c_fix += int'(fixed_clk_en === 1'b1);
    c_slow += int'(slow_clk_en === 1'b1);
    c_a1 += int'(aux1_clk !== aux1_q);
    c_a2 += int'(aux2_clk !== aux2_q);
    aux1_q = aux1_clk;
    aux2_q = aux2_clk;
  end

  task automatic end_of_test;
    if (n_mismatch == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // window counts drift by one because enables lag their ticks, hence tol
  task automatic chk(input int got, input int exp, input int tol);
    compares++;
    if (got < exp - tol || got > exp + tol) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic run(input int n);
    {c_ref, c_pll, c_lf, c_core, c_per, c_usb, c_fix, c_slow, c_a1, c_a2} = '0;
    step(n);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 6; i++) begin
      {mod_rst_req, button, por_req} = 6'h01 << i;
      step(1);
      chk(int'(dev_rst === 1'b1), 1, 0);
      {mod_rst_req, button, por_req} = 6'h00;
      step(1);
      chk(int'(dev_rst === 1'b0), 1, 0);
    end
  endtask
  task automatic t_hs;
    hs_sel_pll = 1'b0;
    run(400);
    chk(c_core, c_ref, 1);
    chk(c_per, c_ref, 1);
    chk(c_usb, c_pll, 1);
    hs_sel_pll = 1'b1;
    for (int s = 0; s < 4; s++) begin
      hs_presc_sel = s[SEL_W-1:0];
      step(20);
      run(400);
      chk(c_core, c_pll / (HS_PRESC_MIN << s), 1);
    end
    hs_sel_pll = 1'b0;
  endtask
  task automatic t_fixed_aux;
    hs_sel_pll = 1'b1;
    hs_presc_sel = 2'h3;
    fixed_div = 8'h09;
    aux1_div = 8'h04;
    aux2_div = 8'h07;
    step(20);
    run(800);
    // fixed rate must ignore the pll selection, aux must follow it
    chk(c_fix, c_ref / 10, 1);
    chk(c_a1, c_pll / 16 / 5, 1);
    chk(c_a2, c_pll / 16 / 8, 1);
    hs_sel_pll = 1'b0;
    step(20);
  endtask
  task automatic t_slow_presc;
    lf_xtal_present = 1'b0;
    step(10);
    run(6100);
    chk(c_slow, c_ref / SLOW_DIV_REF_I, 1);
    lf_xtal_present = 1'b1;
  endtask
  task automatic t_modes;
    mode_req = MREQ_PSAVE;
    for (int i = 0; i < 200 && clk_src_slow !== 1'b1; i++) step(1);
    chk(int'(clk_src_slow === 1'b1), 1, 0);
    run(400);
    chk(c_core, c_lf, 1);
    chk(c_per + c_usb + c_fix + c_a1, 0, 0);
    mode_req = MREQ_IDLE;
    step(3);
    run(400);
    chk(c_core + c_per + c_usb + c_fix + c_a1 + c_a2, 0, 0);
    chk(c_slow, c_lf, 1);
    mode_req = MREQ_HALT;
    step(3);
    run(400);
    chk(c_core + c_per + c_usb + c_fix + c_slow + c_a1 + c_a2, 0, 0);
    mode_req = MREQ_ACTIVE;
    for (int i = 0; i < 200 && clk_src_slow !== 1'b0; i++) step(1);
    chk(int'(clk_src_slow === 1'b0), 1, 0);
    step(3);
    run(400);
    chk(c_core, c_ref, 1);
    chk(int'(c_a1 > 0), 1, 0);
  endtask
  // reset in mid-run: outputs drop to their reset levels, then clocks resume
  task automatic t_mid_reset;
    rst = 1'b1;
    step(2);
    chk(int'({dev_rst, aux1_clk, aux2_clk, core_clk_en} === 4'h8), 1, 0);
    rst = 1'b0;
    step(2);
    chk(int'(dev_rst === 1'b0), 1, 0);
    run(400);
    chk(c_core, c_ref, 1);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    end_of_test;
  end
  initial begin
    {rst, lf_xtal_present, hs_sel_pll, por_req, button} = 5'h19;
    {hs_presc_sel, mode_req, mod_rst_req} = 8'h00;
    {fixed_div, aux1_div, aux2_div} = 24'h030303;
    step(10);
    chk(int'(dev_rst === 1'b1), 1, 0);
    rst = 1'b0;
    step(2);
    t_reset;
    t_hs;
    t_fixed_aux;
    t_slow_presc;
    t_modes;
    t_mid_reset;
    end_of_test;
  end
endmodule
